// ==== design/bvl_pkg.sv ====
// Package of constants, types and helpers for the bitwise logic vector unit
package bvl_pkg;

  // Operator choice, fixed at build time
  typedef enum logic [2:0] {BVL_AND, BVL_NAND, BVL_OR, BVL_NOR, BVL_XOR, BVL_XNOR} bvl_op_t;

  // Build-time limits
  localparam int unsigned BVL_MAX_IN  = 1024;
  localparam int unsigned BVL_FRAC_W  = 8;
  localparam int unsigned BVL_CNT_W   = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0]  BVL_ADDR_CTRL = 8'h00;
  localparam logic [7:0]  BVL_ADDR_STAT = 8'h04;
  localparam logic [7:0]  BVL_ADDR_CONF = 8'h08;

  // Control fields and reset value
  localparam int unsigned BVL_CTRL_EN_BIT  = 0;
  localparam int unsigned BVL_CTRL_CLR_BIT = 1;
  localparam logic        BVL_CTRL_EN_RST  = 1'h1;

  // Config register field position
  localparam int unsigned BVL_CONF_PSC_LSB = 16;

  // AXI responses
  localparam logic [1:0]  BVL_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  BVL_RESP_SLVERR = 2'h2;

  // Largest or smallest binary point among the first n operands
  function automatic int unsigned bvl_frac_ext(input logic [BVL_MAX_IN*BVL_FRAC_W-1:0] f,
                                               input int unsigned n, input bit want_max);
    int unsigned r;
    int unsigned v;
    r = f[BVL_FRAC_W-1:0];
    for (int unsigned i = 1; i < n; i++)
    begin
      v = f[i*BVL_FRAC_W +: BVL_FRAC_W];
      if (want_max ? (v > r) : (v < r))
        r = v;
    end
    return r;
  endfunction : bvl_frac_ext

endpackage : bvl_pkg

// ==== design/bvl_lane_if.sv ====
// Interface carrying one lane's operands and result
`timescale 1ns/10ps
`default_nettype none
interface bvl_lane_if #(
  parameter int unsigned NUM_IN = 2,
  parameter int unsigned W      = 8,
  parameter int unsigned RW     = 8
);
  logic [NUM_IN*W-1:0] ops;
  logic [RW-1:0]       res;

  modport drv  (output ops, input res);
  modport lane (input ops, output res);
endinterface : bvl_lane_if
`default_nettype wire

// ==== design/bvl_lane.sv ====
// One lane of the bitwise logic unit: alignment, operator, reduction
`timescale 1ns/10ps
`default_nettype none
module bvl_lane import bvl_pkg::*; #(
  parameter int unsigned NUM_IN  = 2,
  parameter int unsigned W       = 8,
  parameter int unsigned RW      = 8,
  parameter int unsigned MAXF    = 0,
  parameter bvl_op_t     OP      = BVL_AND,
  parameter bit          ALIGN_EN = 1'b1,
  parameter bit          ARITH_SIGNED = 1'b1,
  parameter logic [NUM_IN*BVL_FRAC_W-1:0] IN_FRAC = '0
)(
  bvl_lane_if.lane lane
);

  localparam bit INVERT = (OP == BVL_NAND) || (OP == BVL_NOR) || (OP == BVL_XNOR);

  // One step of the selected operator on a single bit pair
  function automatic logic op_bit(input logic a, input logic b);
    unique case (OP)
      BVL_AND:  return a & b;
      BVL_NAND: return ~(a & b);
      BVL_OR:   return a | b;
      BVL_NOR:  return ~(a | b);
      BVL_XOR:  return a ^ b;
      BVL_XNOR: return ~(a ^ b);
      default:  return 1'b0;
    endcase
  endfunction : op_bit

  logic [RW-1:0] acc;
  logic [RW-1:0] opnd;
  logic          red;

  // Align each operand and fold the operator across them
  always_comb
  begin
    int sh;
    int src;
    logic [W-1:0] x;
    sh   = 0;
    src  = 0;
    x    = '0;
    acc  = '0;
    opnd = '0;
    red  = 1'b0;
    if (NUM_IN == 1)
    begin
      // Chained from the lowest bit upward
      x   = lane.ops[W-1:0];
      red = x[0];
      for (int k = 1; k < W; k++)
        red = op_bit(red, x[k]);
    end
    else
    begin
      for (int i = 0; i < NUM_IN; i++)
      begin
        x  = lane.ops[i*W +: W];
        sh = ALIGN_EN ? int'(MAXF) - int'(IN_FRAC[i*BVL_FRAC_W +: BVL_FRAC_W]) : 0;
        // Zeros below the point, sign or zero above
        for (int b = 0; b < RW; b++)
        begin
          src = b - sh;
          if (src < 0)
            opnd[b] = 1'b0;
          else if (src < W)
            opnd[b] = x[src];
          else
            opnd[b] = ARITH_SIGNED ? x[W-1] : 1'b0;
        end
        if (i == 0)
          acc = opnd;
        else if (OP == BVL_AND || OP == BVL_NAND)
          acc = acc & opnd;
        else if (OP == BVL_OR || OP == BVL_NOR)
          acc = acc | opnd;
        else
          acc = acc ^ opnd;
      end
      if (INVERT)
        acc = ~acc;
    end
  end

  // Reduction gives one Boolean bit in bit 0
  assign lane.res = (NUM_IN == 1) ? RW'(red) : acc;

endmodule : bvl_lane
`default_nettype wire

// ==== design/bvl_unit.sv ====
// Top of the bitwise logic vector unit with its register slave
`timescale 1ns/10ps
`default_nettype none
// Function
// - One build-time operator from six, bitwise applied
// - Operand count configurable from 1 to 1024
// - Single operand gives a one-bit reduction
// - Reduction chains from lowest bit upward
// - Reduction output is always Boolean
// - Align binary points by zero pad, sign extend
// - Process parallel samples per sample period
module bvl_unit import bvl_pkg::*; #(
  parameter int unsigned NUM_IN                = 2,
  parameter int unsigned W                     = 8,
  parameter int unsigned PARALLEL_SAMPLE_COUNT = 1,
  parameter bvl_op_t     OP                    = BVL_AND,
  parameter bit          ALIGN_EN              = 1'b1,
  parameter bit          ARITH_SIGNED          = 1'b1,
  parameter logic [NUM_IN*BVL_FRAC_W-1:0] IN_FRAC = '0,
  localparam int unsigned PSC  = PARALLEL_SAMPLE_COUNT,
  localparam int unsigned MAXF = ALIGN_EN ?
    bvl_frac_ext((BVL_MAX_IN*BVL_FRAC_W)'(IN_FRAC), NUM_IN, 1'b1) : 0,
  localparam int unsigned MINF = ALIGN_EN ?
    bvl_frac_ext((BVL_MAX_IN*BVL_FRAC_W)'(IN_FRAC), NUM_IN, 1'b0) : 0,
  localparam int unsigned RW   = W + MAXF - MINF
)(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Operand stream
  input  wire logic                  in_valid_i,
  input  wire logic [PSC*NUM_IN*W-1:0] operand_i,
  output logic                       out_valid_o,
  output logic [PSC*RW-1:0]          result_o,
  // AXI4-Lite write address and data
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp
);

  // Refuse configurations the datapath cannot serve
  if (NUM_IN < 1 || NUM_IN > BVL_MAX_IN)
  begin : g_bad_num_in
    $error("operand count out of range");
  end
  if (W < 1 || PSC < 1)
  begin : g_bad_width
    $error("width and parallel sample count must be at least one");
  end

  // Only the six operator codes are served
  if (OP > BVL_XNOR)
  begin : g_bad_op
    $error("operator code outside the six bitwise operators");
  end

  // The config register holds the lane count in sixteen bits
  if (PSC > 32'hFFFF)
  begin : g_bad_psc
    $error("parallel sample count too large for the config register");
  end

  // With alignment off every operand must share one binary point
  for (genvar i = 1; i < NUM_IN; i++)
  begin : g_frac_chk
    if (!ALIGN_EN && (IN_FRAC[i*BVL_FRAC_W +: BVL_FRAC_W] != IN_FRAC[BVL_FRAC_W-1:0]))
    begin : g_bad_frac
      $error("binary points differ while alignment is off");
    end
  end

  // Whole state of the unit
  typedef struct packed {
    logic                  aw_got;
    logic [7:0]            awaddr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  ctrl_en;
    logic [BVL_CNT_W-1:0]  count;
    logic                  out_valid;
    logic [PSC*RW-1:0]     result;
  } bvl_state_t;

  bvl_state_t st;
  bvl_state_t next_st;
  logic [PSC*RW-1:0] lane_res;

  // One lane per parallel sample
  for (genvar g = 0; g < PSC; g++)
  begin : g_lane
    bvl_lane_if #(.NUM_IN(NUM_IN), .W(W), .RW(RW)) lif ();
    assign lif.ops = operand_i[g*NUM_IN*W +: NUM_IN*W];
    assign lane_res[g*RW +: RW] = lif.res;
    bvl_lane #(
      .NUM_IN       (NUM_IN),
      .W            (W),
      .RW           (RW),
      .MAXF         (MAXF),
      .OP           (OP),
      .ALIGN_EN     (ALIGN_EN),
      .ARITH_SIGNED (ARITH_SIGNED),
      .IN_FRAC      (IN_FRAC)
    ) u_lane (
      .lane (lif.lane)
    );
  end

  // Handshake outputs straight from state
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready  = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign out_valid_o   = st.out_valid;
  assign result_o      = st.result;

  // Next-state logic: bus slave, control and result stage
  always_comb
  begin
    next_st = st;
    // Address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    // Perform the write once both halves are held
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = BVL_RESP_OKAY;
      if (st.awaddr == BVL_ADDR_CTRL)
      begin
        if (st.wstrb[0])
        begin
          next_st.ctrl_en = st.wdata[BVL_CTRL_EN_BIT];
          if (st.wdata[BVL_CTRL_CLR_BIT])
            next_st.count = '0;
        end
      end
      // Unmapped write address is refused, read-only words ignore it
      else if (st.awaddr != BVL_ADDR_STAT && st.awaddr != BVL_ADDR_CONF)
        next_st.bresp = BVL_RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = BVL_RESP_OKAY;
      next_st.rdata  = '0;
      unique case (s_axi_araddr)
        BVL_ADDR_CTRL: next_st.rdata[BVL_CTRL_EN_BIT] = st.ctrl_en;
        BVL_ADDR_STAT: next_st.rdata[BVL_CNT_W-1:0] = st.count;
        BVL_ADDR_CONF:
        begin
          next_st.rdata[BVL_CONF_PSC_LSB +: 16] = 16'(PSC);
          next_st.rdata[15:0]                   = 16'(NUM_IN);
        end
        default:       next_st.rresp = BVL_RESP_SLVERR;
      endcase
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    // Result stage; a new result in the same cycle as a counter clear counts from zero, leaving one
    next_st.out_valid = 1'b0;
    if (in_valid_i && st.ctrl_en)
    begin
      next_st.out_valid = 1'b1;
      next_st.result    = lane_res;
      next_st.count     = next_st.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      // Everything clears except the enable, which comes up set
      st         <= '0;
      st.ctrl_en <= BVL_CTRL_EN_RST;
    end
    else
      st <= next_st;
  end

endmodule : bvl_unit
`default_nettype wire

// ==== dv/bvl_opnd_src.sv ====
// Operand source standing in for the neighbouring datapath logic
`timescale 1ns/10ps
`default_nettype none
module bvl_opnd_src #(
  parameter int unsigned DW = 32
)(
  // Clock
  input  wire logic          clk_i,
  // Operand stream
  output logic               vld_o,
  output logic [DW-1:0]      data_o
);
  // Offer one operand set; release shows the inverse, not a stale copy
  task put(input logic [DW-1:0] d, input bit more);
    vld_o  <= 1'b1;
    data_o <= d;
    @(posedge clk_i);
    if (!more)
    begin
      vld_o  <= 1'b0;
      data_o <= ~d;
    end
  endtask : put
endmodule : bvl_opnd_src
`default_nettype wire

// ==== dv/bvl_unit_asserts.sv ====
// Port timing checker for the bitwise logic vector unit
`timescale 1ns/10ps
`default_nettype none
module bvl_unit_asserts #(
  parameter int unsigned RES_W = 8
)(
  // Clock, reset, stream
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  input wire logic             in_valid_i,
  input wire logic             out_valid_o,
  input wire logic [RES_W-1:0] result_o,
  // Register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Bus steps
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_out_cause; out_valid_o |-> $past(in_valid_i); endproperty
  property p_no_in; !in_valid_i |=> !out_valid_o; endproperty
  property p_res_hold; !out_valid_o |-> $stable(result_o); endproperty
  property p_wr_ans; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rd_ans; s_rd_take |=> s_axi_rvalid ##1 (!s_axi_rvalid || !s_axi_rready); endproperty
  property p_rd_err;
    s_rd_take and (s_axi_araddr > 8'h08) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("result without operands");
  a_no_in: assert property (p_no_in) else $error("result pulse too long");
  a_res_hold: assert property (p_res_hold) else $error("result moved while idle");
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_b_block: assert property (p_b_block) else $error("write taken while responding");
  a_b_one: assert property (p_b_one) else $error("write response held");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong timing");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
endmodule : bvl_unit_asserts
bind bvl_unit bvl_unit_asserts #(.RES_W(PSC*RW)) i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .in_valid_i(in_valid_i), .out_valid_o(out_valid_o), .result_o(result_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));
`default_nettype wire

// ==== dv/bvl_unit_tb.sv ====
// Register and datapath testbench for the bitwise logic vector unit
`timescale 1ns/10ps
`default_nettype none
module bvl_unit_tb import bvl_pkg::*;;
  localparam int unsigned RW = 10;
  logic clk_i, sys_rst_i, in_valid_i, out_valid_o;
  logic [31:0] operand_i, s_axi_wdata, s_axi_rdata;
  logic [2*RW-1:0] result_o;
  logic [31:0] wd, exq[$];
  logic [15:0] res_red;
  logic [3:0] res_nor, strb;
  logic ov_red, ov_nor;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [7:0] aw_a, ar_a;
  logic [1:0] b_resp, r_resp;
  int err_total, n_tests;
  bvl_opnd_src #(.DW(32)) i_src (.clk_i(clk_i), .vld_o(in_valid_i), .data_o(operand_i));
  bvl_unit #(.NUM_IN(2), .W(8), .PARALLEL_SAMPLE_COUNT(2), .OP(BVL_XNOR),
    .IN_FRAC(16'h0200)) i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .in_valid_i(in_valid_i),
    .operand_i(operand_i), .out_valid_o(out_valid_o), .result_o(result_o),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_bresp(b_resp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(r_resp));
  // Reduction: one operand per lane folded to one bit
  bvl_unit #(.NUM_IN(1), .W(8), .PARALLEL_SAMPLE_COUNT(2), .OP(BVL_XOR)) i_dut_red (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .in_valid_i(in_valid_i),
    .operand_i(operand_i[15:0]), .out_valid_o(ov_red), .result_o(res_red),
    .s_axi_awvalid(aw_v), .s_axi_awready(), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
    .s_axi_wready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb), .s_axi_bvalid(),
    .s_axi_bready(b_r), .s_axi_bresp(), .s_axi_arvalid(ar_v), .s_axi_arready(),
    .s_axi_araddr(ar_a), .s_axi_rvalid(), .s_axi_rready(r_r), .s_axi_rdata(), .s_axi_rresp());
  // Alignment off: the source gives all three operands one binary point
  bvl_unit #(.NUM_IN(3), .W(4), .OP(BVL_NOR), .ALIGN_EN(1'b0),
    .IN_FRAC(24'h030303)) i_dut_nor (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .in_valid_i(in_valid_i),
    .operand_i(operand_i[11:0]), .out_valid_o(ov_nor), .result_o(res_nor),
    .s_axi_awvalid(aw_v), .s_axi_awready(), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
    .s_axi_wready(), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(strb), .s_axi_bvalid(),
    .s_axi_bready(b_r), .s_axi_bresp(), .s_axi_arvalid(ar_v), .s_axi_arready(),
    .s_axi_araddr(ar_a), .s_axi_rvalid(), .s_axi_rready(r_r), .s_axi_rdata(), .s_axi_rresp());
  // Clock and watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #20000;
    err_total++;
    end_sim();
  end
  // Expected lanes: operand 0 padded by two zeros, operand 1 sign extended
  function automatic logic [2*RW-1:0] expf(input logic [31:0] d);
    logic [RW-1:0] a, b;
    for (int g = 0; g < 2; g++)
    begin
      a = {d[g*16 +: 8], 2'b00};
      b = {{2{d[g*16+15]}}, d[g*16+8 +: 8]};
      expf[g*RW +: RW] = ~(a ^ b);
    end
  endfunction : expf
  // Expected reduction lanes: parity bit in bit 0, upper bits zero
  function automatic logic [15:0] expr(input logic [31:0] d);
    for (int g = 0; g < 2; g++)
      expr[g*8 +: 8] = {7'h00, ^d[g*8 +: 8]};
  endfunction : expr
  // Expected three-operand NOR
  function automatic logic [3:0] expn(input logic [31:0] d);
    return ~(d[3:0] | d[7:4] | d[11:8]);
  endfunction : expn
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask : chk
  // Result watcher
  always @(negedge clk_i)
    if (out_valid_o === 1'b1)
    begin
      wd = exq.size() ? exq.pop_front() : 'x;
      chk(32'(result_o), 32'(expf(wd)));
      chk(32'(res_red), 32'(expr(wd)));
      chk(32'(res_nor), 32'(expn(wd)));
      chk(32'({ov_red, ov_nor}), 32'h3);
    end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v <= 1'b1;
    s_axi_wdata <= d;
    fork
      begin do @(posedge clk_i); while (!aw_r); aw_v <= 1'b0; end
      begin do @(posedge clk_i); while (!w_r); w_v <= 1'b0; end
    join
    while (!b_v) @(posedge clk_i);
    chk(32'(b_resp), 32'(r));
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    ar_v <= 1'b1;
    ar_a <= a;
    do @(posedge clk_i); while (!ar_r);
    ar_v <= 1'b0;
    do @(posedge clk_i); while (!r_v);
    chk(s_axi_rdata, d);
    chk(32'(r_resp), 32'(r));
  endtask : rd
  task smp(input logic [31:0] d, input bit more, input bit en);
    if (en) exq.push_back(d);
    i_src.put(d, more);
  endtask : smp
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    {aw_v, w_v, ar_v, aw_a, ar_a, s_axi_wdata} = '0;
    strb = 4'hF;
    {b_r, r_r, sys_rst_i} = 3'h7;
    i_src.vld_o = 1'b0;
    i_src.data_o = '0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(BVL_ADDR_CTRL, 32'h1, BVL_RESP_OKAY);
    rd(BVL_ADDR_CONF, 32'h0002_0002, BVL_RESP_OKAY);
    rd(8'h0C, 32'h0, BVL_RESP_SLVERR);
    wr(8'h10, 32'h1, BVL_RESP_SLVERR);
    wr(BVL_ADDR_STAT, 32'hFFFF, BVL_RESP_OKAY);
    strb <= 4'h0;
    wr(BVL_ADDR_CTRL, 32'h0, BVL_RESP_OKAY);
    strb <= 4'hF;
    rd(BVL_ADDR_CTRL, 32'h1, BVL_RESP_OKAY);
    $display("register test done");
    smp(32'h7F80_01FF, 1, 1);
    smp(32'h807F_55AA, 1, 1);
    smp(32'hFF00_00FF, 0, 1);
    repeat (2) @(posedge clk_i);
    rd(BVL_ADDR_STAT, 32'h3, BVL_RESP_OKAY);
    $display("stream test done");
    wr(BVL_ADDR_CTRL, 32'h0, BVL_RESP_OKAY);
    smp(32'h1234_5678, 0, 0);
    repeat (3) @(posedge clk_i);
    rd(BVL_ADDR_STAT, 32'h3, BVL_RESP_OKAY);
    wr(BVL_ADDR_CTRL, 32'h3, BVL_RESP_OKAY);
    rd(BVL_ADDR_CTRL, 32'h1, BVL_RESP_OKAY);
    smp(32'h0180_80FE, 0, 1);
    repeat (2) @(posedge clk_i);
    rd(BVL_ADDR_STAT, 32'h1, BVL_RESP_OKAY);
    chk(32'(exq.size()), 32'h0);
    $display("gating test done");
    end_sim();
  end
endmodule : bvl_unit_tb
`default_nettype wire
